// >>> hw/mrr_pkg.sv
// package for the minimum and latest result register bank
// assumes an 8-bit register address space and a 12-bit converter
package mrr_pkg;

   // widths
   localparam int unsigned CODE_W = 12;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CHAN_W = 3;
   localparam int unsigned PAD_W = 4;

   // register offsets
   localparam logic [7:0] ADDR_LOWEST_CHAN6_HIGH = 8'h8d;
   localparam logic [7:0] ADDR_LOWEST_CHAN7_LOW = 8'h8e;
   localparam logic [7:0] ADDR_LOWEST_CHAN7_HIGH = 8'h8f;
   localparam logic [7:0] ADDR_LATEST_CHAN0_LOW = 8'ha0;
   localparam logic [7:0] ADDR_LATEST_CHAN0_HIGH = 8'ha1;
   localparam logic [7:0] ADDR_LATEST_CHAN1_LOW = 8'ha2;
   localparam logic [7:0] ADDR_LATEST_CHAN1_HIGH = 8'ha3;

   // reset and reload values
   localparam logic [7:0] LOWEST_BYTE_RESET = 8'hff;
   localparam logic [15:0] LOWEST_WORD_RESET = 16'hffff;
   localparam logic [7:0] LATEST_BYTE_RESET = 8'h00;
   localparam logic [15:0] LATEST_WORD_RESET = 16'h0000;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [3:0] ALIGN_PAD = 4'h0;

   // channel numbers covered here
   localparam logic [2:0] CHAN_LATEST_BASE = 3'h0;
   localparam logic [2:0] CHAN_LOWEST_BASE = 3'h6;
   localparam int unsigned NUM_LATEST = 2;
   localparam int unsigned NUM_LOWEST = 2;

endpackage

// >>> hw/mrr_lowest_track.sv
// one channel of minimum-code tracking with per-byte reload on read
// assumes codes arrive already aligned to the top of a 16-bit word
`timescale 1ns/100ps
`default_nettype none
module mrr_lowest_track (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // new result
   input wire logic upd_i,
   input wire logic [15:0] code_i,
   // read side effects
   input wire logic clr_hi_i,
   input wire logic clr_lo_i,
   // held minimum
   output logic [15:0] lowest_o
);
   logic [15:0] base;
   logic [15:0] lowest_d;

   // a read reloads its byte first, so a result in the same cycle still lands
   always_comb begin
      base[15:8] = clr_hi_i ? mrr_pkg::LOWEST_BYTE_RESET : lowest_o[15:8];
      base[7:0] = clr_lo_i ? mrr_pkg::LOWEST_BYTE_RESET : lowest_o[7:0];
      lowest_d = base;
      if (upd_i && (code_i < base)) begin
         lowest_d = code_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         lowest_o <= mrr_pkg::LOWEST_WORD_RESET;
      end else begin
         lowest_o <= lowest_d;
      end
   end
endmodule
`default_nettype wire

// >>> hw/mrr_latest_pair.sv
// one channel's latest result, high byte over low byte
// assumes codes arrive already aligned to the top of a 16-bit word
`timescale 1ns/100ps
`default_nettype none
module mrr_latest_pair (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // new result
   input wire logic upd_i,
   input wire logic [15:0] code_i,
   // held result
   output logic [15:0] latest_o
);
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         latest_o <= mrr_pkg::LATEST_WORD_RESET;
      end else if (upd_i) begin
         latest_o <= code_i;
      end
   end
endmodule
`default_nettype wire

// >>> hw/mrr_bank.sv
// minimum and latest result register bank of the converter
// assumes reads and writes come as one-cycle strobes from the serial
// register port logic on the same clock, and results from the converter
`timescale 1ns/100ps
`default_nettype none
module mrr_bank (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // conversion results
   input wire logic conv_valid_i,
   input wire logic [2:0] conv_chan_i,
   input wire logic [11:0] conv_code_i,
   // register port
   input wire logic reg_rd_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o
);
   logic [15:0] code_aligned;
   logic [15:0] lowest [mrr_pkg::NUM_LOWEST];
   logic [15:0] latest [mrr_pkg::NUM_LATEST];
   logic [mrr_pkg::NUM_LOWEST-1:0] lowest_upd;
   logic [mrr_pkg::NUM_LATEST-1:0] latest_upd;
   logic [mrr_pkg::NUM_LOWEST-1:0] clr_hi;
   logic [mrr_pkg::NUM_LOWEST-1:0] clr_lo;
   logic [7:0] rdata_d;

   // 12-bit code placed at the top so the high byte carries the first 8 bits
   assign code_aligned = {conv_code_i, mrr_pkg::ALIGN_PAD};

   // chan 6 low byte lives outside this bank, so it is never reloaded here
   assign clr_hi[0] = reg_rd_i && (reg_addr_i == mrr_pkg::ADDR_LOWEST_CHAN6_HIGH);
   assign clr_lo[0] = 1'b0;
   assign clr_hi[1] = reg_rd_i && (reg_addr_i == mrr_pkg::ADDR_LOWEST_CHAN7_HIGH);
   assign clr_lo[1] = reg_rd_i && (reg_addr_i == mrr_pkg::ADDR_LOWEST_CHAN7_LOW);

   genvar gi;
   generate
      for (gi = 0; gi < mrr_pkg::NUM_LOWEST; gi++) begin : g_lowest
         assign lowest_upd[gi] = conv_valid_i &&
            (conv_chan_i == mrr_pkg::CHAN_LOWEST_BASE + 3'(gi));
         mrr_lowest_track u_track (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .upd_i(lowest_upd[gi]),
            .code_i(code_aligned),
            .clr_hi_i(clr_hi[gi]),
            .clr_lo_i(clr_lo[gi]),
            .lowest_o(lowest[gi])
         );
      end
      for (gi = 0; gi < mrr_pkg::NUM_LATEST; gi++) begin : g_latest
         assign latest_upd[gi] = conv_valid_i &&
            (conv_chan_i == mrr_pkg::CHAN_LATEST_BASE + 3'(gi));
         mrr_latest_pair u_pair (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .upd_i(latest_upd[gi]),
            .code_i(code_aligned),
            .latest_o(latest[gi])
         );
      end
   endgenerate

   // read mux; writes are not decoded at all, which keeps every byte read only
   always_comb begin
      case (reg_addr_i)
         mrr_pkg::ADDR_LOWEST_CHAN6_HIGH: rdata_d = lowest[0][15:8];
         mrr_pkg::ADDR_LOWEST_CHAN7_LOW: rdata_d = lowest[1][7:0];
         mrr_pkg::ADDR_LOWEST_CHAN7_HIGH: rdata_d = lowest[1][15:8];
         mrr_pkg::ADDR_LATEST_CHAN0_LOW: rdata_d = latest[0][7:0];
         mrr_pkg::ADDR_LATEST_CHAN0_HIGH: rdata_d = latest[0][15:8];
         mrr_pkg::ADDR_LATEST_CHAN1_LOW: rdata_d = latest[1][7:0];
         mrr_pkg::ADDR_LATEST_CHAN1_HIGH: rdata_d = latest[1][15:8];
         default: rdata_d = mrr_pkg::UNMAPPED_READ;
      endcase
   end

   // the value before the reload is what goes out, so nothing is lost to a read
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= mrr_pkg::UNMAPPED_READ;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   logic rst_seen_q;
   always_ff @(posedge clock_i) begin
      rst_seen_q <= !rst_n_i;
   end

   chk_lowest_reset_ones: assert property (
      rst_seen_q |-> (lowest[0] == 16'hffff) && (lowest[1] == 16'hffff))
      else $error("minimum bytes not all ones after reset");

   chk_latest_reset_zero: assert property (
      rst_seen_q |-> (latest[0] == 16'h0000) && (latest[1] == 16'h0000))
      else $error("latest bytes not zero after reset");

   chk_read_ret_held: assert property (
      reg_rd_i && (reg_addr_i == 8'h8d) |=>
         reg_rvalid_o && (reg_rdata_o == $past(lowest[0][15:8])))
      else $error("minimum read did not return held value");

   chk_read_reload_ff: assert property (
      reg_rd_i && (reg_addr_i == 8'h8f) && !conv_valid_i |=>
         (lowest[1][15:8] == 8'hff) && (lowest[1][7:0] == $past(lowest[1][7:0])))
      else $error("minimum byte not reloaded after read");

   chk_lowest_map_low: assert property (
      reg_rd_i && (reg_addr_i == 8'h8e) |=> reg_rdata_o == $past(lowest[1][7:0]))
      else $error("chan 7 low minimum at wrong offset");

   chk_lowest_tracks: assert property (
      conv_valid_i && (conv_chan_i == 3'h7) |=>
         lowest[1] <= $past(code_aligned))
      else $error("minimum above a fresh result");

   chk_lowest_strict: assert property (
      conv_valid_i && (conv_chan_i == 3'h6) && !reg_rd_i &&
         (code_aligned >= lowest[0]) |=> $stable(lowest[0]))
      else $error("minimum replaced by a code not strictly smaller");

   chk_latest_high: assert property (
      conv_valid_i && (conv_chan_i == 3'h0) |=>
         latest[0][15:8] == $past(conv_code_i[11:4]))
      else $error("latest high byte not top 8 bits");

   chk_latest_low: assert property (
      conv_valid_i && (conv_chan_i == 3'h1) |=>
         latest[1][7:0] == {$past(conv_code_i[3:0]), 4'h0})
      else $error("latest low byte not next bits");

   chk_latest_map: assert property (
      reg_rd_i && (reg_addr_i == 8'ha2) |=> reg_rdata_o == $past(latest[1][7:0]))
      else $error("chan 1 low latest at wrong offset");

   chk_latest_map_hi: assert property (
      reg_rd_i && (reg_addr_i == 8'ha3) |=> reg_rdata_o == $past(latest[1][15:8]))
      else $error("chan 1 high latest at wrong offset");

   chk_write_no_effect: assert property (
      reg_wr_i && !reg_rd_i && !conv_valid_i && (reg_wdata_i != 8'h00) |=>
         $stable(lowest[0]) && $stable(lowest[1]) &&
         $stable(latest[0]) && $stable(latest[1]))
      else $error("write changed a read-only register");

   chk_rvalid_pulse: assert property (
      reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered one cycle later");

   chk_rvalid_quiet: assert property (
      !reg_rd_i |=> !reg_rvalid_o)
      else $error("read answer without a read");

   chk_rdata_holds: assert property (
      !reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");

   chk_port_reset: assert property (
      rst_seen_q |-> (reg_rdata_o == 8'h00) && !reg_rvalid_o)
      else $error("register port not quiet after reset");

   chk_unmapped_zero: assert property (
      reg_rd_i && !(reg_addr_i inside {8'h8d, 8'h8e, 8'h8f, [8'ha0:8'ha3]}) |=>
         reg_rdata_o == 8'h00)
      else $error("unmapped address did not read zero");

   chk_lowest_map_high: assert property (
      reg_rd_i && (reg_addr_i == 8'h8f) |=> reg_rdata_o == $past(lowest[1][15:8]))
      else $error("chan 7 high minimum at wrong offset");

   chk_latest_map_chan0: assert property (
      reg_rd_i && (reg_addr_i == 8'ha0) |=> reg_rdata_o == $past(latest[0][7:0]))
      else $error("chan 0 low latest at wrong offset");

   chk_latest_map_chan0_hi: assert property (
      reg_rd_i && (reg_addr_i == 8'ha1) |=> reg_rdata_o == $past(latest[0][15:8]))
      else $error("chan 0 high latest at wrong offset");

   chk_reload_chan7_low: assert property (
      reg_rd_i && (reg_addr_i == 8'h8e) && !conv_valid_i |=>
         (lowest[1][7:0] == 8'hff) && (lowest[1][15:8] == $past(lowest[1][15:8])))
      else $error("chan 7 low minimum not reloaded alone");

   chk_reload_chan6_high: assert property (
      reg_rd_i && (reg_addr_i == 8'h8d) && !conv_valid_i |=>
         (lowest[0][15:8] == 8'hff) && (lowest[0][7:0] == $past(lowest[0][7:0])))
      else $error("chan 6 high minimum not reloaded alone");

   // a result in the cycle of a read is compared against the reloaded byte
   chk_read_conv_take: assert property (
      reg_rd_i && (reg_addr_i == 8'h8d) && conv_valid_i && (conv_chan_i == 3'h6) &&
         (code_aligned < {8'hff, lowest[0][7:0]}) |=> lowest[0] == $past(code_aligned))
      else $error("result lost to a minimum reload in the same cycle");

   chk_read_conv_keep: assert property (
      reg_rd_i && (reg_addr_i == 8'h8d) && conv_valid_i && (conv_chan_i == 3'h6) &&
         (code_aligned >= {8'hff, lowest[0][7:0]}) |=>
         lowest[0] == {8'hff, $past(lowest[0][7:0])})
      else $error("minimum reload wrong beside a larger result");

   chk_chan6_tracks: assert property (
      conv_valid_i && (conv_chan_i == 3'h6) |=> lowest[0] <= $past(code_aligned))
      else $error("chan 6 minimum above a fresh result");

   chk_lowest_takes: assert property (
      conv_valid_i && (conv_chan_i == 3'h7) && (code_aligned < lowest[1]) |=>
         lowest[1] == $past(code_aligned))
      else $error("strictly smaller result not taken");

   chk_lowest_no_rise: assert property (
      !reg_rd_i |=> (lowest[0] <= $past(lowest[0])) && (lowest[1] <= $past(lowest[1])))
      else $error("minimum rose without a read");

   chk_lowest_idle: assert property (
      !reg_rd_i && !conv_valid_i |=> $stable(lowest[0]) && $stable(lowest[1]))
      else $error("minimum moved with no result and no read");

   chk_other_chan: assert property (
      conv_valid_i && (conv_chan_i inside {[3'h2:3'h5]}) && !reg_rd_i |=>
         $stable(lowest[0]) && $stable(lowest[1]) &&
         $stable(latest[0]) && $stable(latest[1]))
      else $error("result of an uncovered channel changed a register");

   chk_latest_hold0: assert property (
      !(conv_valid_i && (conv_chan_i == 3'h0)) |=> $stable(latest[0]))
      else $error("chan 0 latest moved without a result");

   chk_latest_hold1: assert property (
      !(conv_valid_i && (conv_chan_i == 3'h1)) |=> $stable(latest[1]))
      else $error("chan 1 latest moved without a result");

   chk_latest_high1: assert property (
      conv_valid_i && (conv_chan_i == 3'h1) |=>
         latest[1][15:8] == $past(conv_code_i[11:4]))
      else $error("chan 1 latest high byte not top 8 bits");

   chk_latest_low0: assert property (
      conv_valid_i && (conv_chan_i == 3'h0) |=>
         latest[0][7:0] == {$past(conv_code_i[3:0]), 4'h0})
      else $error("chan 0 latest low byte not next bits");

   // a 12-bit code never reaches the bottom nibble of the low byte
   chk_latest_pad: assert property (
      (latest[0][3:0] == 4'h0) && (latest[1][3:0] == 4'h0))
      else $error("latest low byte carries bits beyond the code");

   chk_write_latest: assert property (
      reg_wr_i && !conv_valid_i |=> $stable(latest[0]) && $stable(latest[1]))
      else $error("write changed a latest result");

   cov_read_min: cover property (
      conv_valid_i && (conv_chan_i == 3'h7) ##1 reg_rd_i && (reg_addr_i == 8'h8f));
   cov_read_conv_same: cover property (
      reg_rd_i && (reg_addr_i == 8'h8d) && conv_valid_i && (conv_chan_i == 3'h6));
   cov_latest_read: cover property (
      conv_valid_i && (conv_chan_i == 3'h0) ##1 reg_rd_i && (reg_addr_i == 8'ha1));
   cov_write_try: cover property (reg_wr_i && (reg_addr_i == 8'ha0));
   cov_unmapped_read: cover property (reg_rd_i && (reg_addr_i == 8'h8c));
endmodule
`default_nettype wire

// >>> testbench/mrr_host_model.sv
// host controller model driving the register port of the bank
// assumes the bank takes a strobe on the rising edge and answers one cycle later
`timescale 1ns/100ps
`default_nettype none
module mrr_host_model (
   // clock
   input wire logic clock_i,
   // register port
   output logic reg_rd_o,
   output logic reg_wr_o,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o
);
   initial begin
      reg_rd_o = 1'b0;
      reg_wr_o = 1'b0;
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
   end
   // one strobe cycle; calls may follow back to back
   task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      reg_rd_o <= ~wr;
      reg_wr_o <= wr;
      reg_addr_o <= a;
      reg_wdata_o <= d;
   endtask
   // released lines flip so a stale address never looks valid
   task automatic idle();
      @(posedge clock_i);
      reg_rd_o <= 1'b0;
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~reg_addr_o;
      reg_wdata_o <= ~reg_wdata_o;
      repeat (3) @(posedge clock_i);
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb_min_and_recent_result_regs.sv
// self-checking bench for the minimum and latest result register bank
// assumes mrr_host_model drives the register port; results come from here
`timescale 1ns/100ps
`default_nettype none
module tb_min_and_recent_result_regs;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic conv_valid_i = 1'b0;
   logic [2:0] conv_chan_i = 3'h0;
   logic [11:0] conv_code_i = 12'h000;
   logic reg_rd_i;
   logic reg_wr_i;
   logic [7:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic [7:0] reg_rdata_o;
   logic reg_rvalid_o;
   logic [15:0] low_w [8];
   logic [15:0] last_w [2];
   logic [7:0] exp_q [$];
   int error_cnt = 0;
   int n_checks = 0;
   int cyc = 0;
   always #2.5 clock_i = ~clock_i;
   mrr_host_model host (.clock_i(clock_i), .reg_rd_o(reg_rd_i), .reg_wr_o(reg_wr_i),
      .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
   mrr_bank dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .conv_valid_i(conv_valid_i),
      .conv_chan_i(conv_chan_i), .conv_code_i(conv_code_i), .reg_rd_i(reg_rd_i),
      .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // read: note the expected byte, then apply the reload of a minimum byte
   task automatic rd(input logic [7:0] a);
      logic [7:0] e;
      logic [2:0] ch;
      e = 8'h00;
      ch = {2'b11, a[1]};
      if (a inside {8'h8d, 8'h8e, 8'h8f}) begin
         e = a[0] ? low_w[ch][15:8] : low_w[ch][7:0];
         if (a[0]) low_w[ch][15:8] = 8'hff;
         else low_w[ch][7:0] = 8'hff;
      end
      if (a inside {[8'ha0:8'ha3]}) e = a[0] ? last_w[a[1]][15:8] : last_w[a[1]][7:0];
      exp_q.push_back(e);
      host.access(1'b0, a, 8'h00);
   endtask
   // every byte of the bank and its unmapped neighbours, back to back
   task automatic rd_all();
      for (int a = 8'h8c; a <= 8'ha4; a++) begin
         if (a <= 8'h8f || a >= 8'ha0) rd(8'(a));
      end
      host.idle();
   endtask
   task automatic conv(input logic [2:0] c, input logic [11:0] k);
      @(posedge clock_i);
      conv_valid_i <= 1'b1;
      conv_chan_i <= c;
      conv_code_i <= k;
      if (c >= 3'h6 && {k, 4'h0} < low_w[c]) low_w[c] = {k, 4'h0};
      if (c <= 3'h1) last_w[c[0]] = {k, 4'h0};
   endtask
   task automatic conv_idle();
      @(posedge clock_i);
      conv_valid_i <= 1'b0;
      conv_chan_i <= 3'($urandom);
      conv_code_i <= ~conv_code_i;
   endtask
   // scoreboard: each answer takes the oldest note
   always @(posedge clock_i) begin
      if (rst_n_i && reg_rvalid_o !== 1'b0) begin
         if (exp_q.size() == 0) check(8'(exp_q.size()), 8'h01);
         else check(reg_rdata_o, exp_q.pop_front());
      end
   end
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(6193));
      foreach (low_w[i]) low_w[i] = 16'hffff;
      foreach (last_w[i]) last_w[i] = 16'h0000;
      repeat (20) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd_all();
      $display("test 1 reset values done");
      // boundary codes first, then random traffic on every channel
      conv(3'h6, 12'hfff);
      conv(3'h7, 12'h000);
      conv(3'h0, 12'habc);
      conv_idle();
      rd_all();
      for (int r = 0; r < 3; r++) begin
         for (int i = 0; i < 30; i++) conv(3'($urandom), 12'($urandom));
         conv_idle();
         rd(8'h8e);
         host.idle();
         rd_all();
      end
      $display("test 2 results and minimum tracking done");
      for (int i = 0; i < 6; i++) conv(3'($urandom_range(7, 6)), 12'($urandom));
      conv(3'h1, 12'($urandom));
      conv_idle();
      for (int a = 8'h8c; a <= 8'ha4; a++) host.access(1'b1, 8'(a), 8'($urandom));
      host.idle();
      rd_all();
      $display("test 3 writes ignored done");
      // a chan 6 result in the very cycle of its minimum read must survive
      fork
         rd(8'h8d);
         conv(3'h6, 12'($urandom));
      join
      fork
         conv_idle();
         host.idle();
      join
      rd_all();
      // reset again with non-default latest results and chan 6 low minimum; the other minimum bytes are ff after the reads
      @(posedge clock_i);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      foreach (low_w[i]) low_w[i] = 16'hffff;
      foreach (last_w[i]) last_w[i] = 16'h0000;
      rst_n_i <= 1'b1;
      rd_all();
      $display("test 4 read collision and second reset done");
      repeat (4) @(posedge clock_i);
      check(8'(exp_q.size()), 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
